//--- rtl/pls_core.sv
// pulse latch, fault inhibit, restart counter and axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module pls_core
  import pls_pkg::*;
(
  input wire logic CORE_CLK_IN, // 40 mhz system clock
  input wire logic RST_N_IN, // async reset, active low
  input wire logic OSC_PULSE_IN, // oscillator pulse, high active
  input wire logic TRIP_IN, // current-loop comparator trip
  input wire logic OTEMP_OK_IN, // temperature sensor, low = hot
  input wire logic SHDN_OK_IN, // shutdown comparator, low = shut
  input wire logic LOCK_IN, // supply lockout active, high
  input wire logic STARTUP_EN_IN, // start-up circuit enabled, high
  input wire logic [7:0] AWADDR_IN, // axi write address
  input wire logic AWVALID_IN, // axi write address valid
  output logic AWREADY_OUT, // axi write address ready
  input wire logic [31:0] WDATA_IN, // axi write data
  input wire logic [3:0] WSTRB_IN, // axi write strobes
  input wire logic WVALID_IN, // axi write data valid
  output logic WREADY_OUT, // axi write data ready
  output logic [1:0] BRESP_OUT, // axi write response
  output logic BVALID_OUT, // axi write response valid
  input wire logic BREADY_IN, // axi write response ready
  input wire logic [7:0] ARADDR_IN, // axi read address
  input wire logic ARVALID_IN, // axi read address valid
  output logic ARREADY_OUT, // axi read address ready
  output logic [31:0] RDATA_OUT, // axi read data
  output logic [1:0] RRESP_OUT, // axi read response
  output logic RVALID_OUT, // axi read valid
  input wire logic RREADY_IN, // axi read ready
  output logic DRIVE_OUT, // gate drive, high = conduct
  output logic IRQ_OUT // interrupt level, high active
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [5:0] raw_in;
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  assign raw_in = {STARTUP_EN_IN, LOCK_IN, SHDN_OK_IN, OTEMP_OK_IN,
                   TRIP_IN, OSC_PULSE_IN};

  // two flops per indicator; sync1 read only by sync2
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sync1_reg <= PLS_SYNC_RST;
      sync2_reg <= PLS_SYNC_RST;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire osc_s = sync2_reg[0];
  wire trip_s = sync2_reg[1];
  wire otemp_ok_s = sync2_reg[2];
  wire shdn_ok_s = sync2_reg[3];
  wire lock_s = sync2_reg[4];
  wire sue_s = sync2_reg[5];

  // ---------------------------------------------------------------
  // edge detection on synchronised levels
  // ---------------------------------------------------------------
  logic osc_d_reg;
  logic sue_d_reg;
  logic otemp_d_reg;
  logic shdn_d_reg;
  logic lock_d_reg;
  logic trip_d_reg;
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      osc_d_reg <= 1'b0;
      sue_d_reg <= 1'b0;
      otemp_d_reg <= 1'b1;
      shdn_d_reg <= 1'b1;
      lock_d_reg <= 1'b0;
      trip_d_reg <= 1'b0;
    end else begin
      osc_d_reg <= osc_s;
      sue_d_reg <= sue_s;
      otemp_d_reg <= otemp_ok_s;
      shdn_d_reg <= shdn_ok_s;
      lock_d_reg <= lock_s;
      trip_d_reg <= trip_s;
    end
  end
  wire osc_fall = osc_d_reg & ~osc_s;
  wire sue_fall = sue_d_reg & ~sue_s;

  // ---------------------------------------------------------------
  // restart counter, 3 bits; 0 after 7 stands for count eight
  // ---------------------------------------------------------------
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  wire cnt_rst_n = shdn_ok_s;
  wire cnt_eight = (cnt_reg == PLS_CNT_RUN);

  // reset holds seven; fall of start-up enable steps the count
  assign cnt_next = !cnt_rst_n ? PLS_CNT_PRESET :
                    sue_fall ? cnt_reg + 3'h1 :
                    cnt_reg;

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cnt_reg <= PLS_CNT_PRESET;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // inhibit path and pulse latch
  // ---------------------------------------------------------------
  logic run_reg;
  wire fault = ~otemp_ok_s | ~shdn_ok_s | lock_s | ~cnt_eight
               | ~run_reg;
  wire inhibit = osc_s | fault;

  logic latch_reg;
  logic latch_next;
  // set wins; set by trip, reset by oscillator pulse
  assign latch_next = trip_s ? 1'b1 :
                      osc_s ? 1'b0 :
                      latch_reg;
  logic drive_reg;
  // drive rises after pulse fall while latch clear and no inhibit
  wire drive_next = ~inhibit & ~latch_next &
                    (osc_fall | drive_reg);

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      latch_reg <= 1'b1;
      drive_reg <= 1'b0;
    end else begin
      latch_reg <= latch_next;
      drive_reg <= drive_next;
    end
  end
  assign DRIVE_OUT = drive_reg;

  // ---------------------------------------------------------------
  // event status, mask and interrupt
  // ---------------------------------------------------------------
  logic [4:0] stat_reg;
  logic [4:0] mask_reg;
  logic irq_reg;
  logic [4:0] ev;
  assign ev[PLS_EV_TRIP] = trip_s & ~trip_d_reg;
  assign ev[PLS_EV_OTEMP] = otemp_d_reg & ~otemp_ok_s;
  assign ev[PLS_EV_SHDN] = shdn_d_reg & ~shdn_ok_s;
  assign ev[PLS_EV_LOCK] = lock_s & ~lock_d_reg;
  assign ev[PLS_EV_RESTART] = sue_fall & (cnt_next == PLS_CNT_RUN);
  wire irq_any = |(stat_reg & mask_reg);

  // ---------------------------------------------------------------
  // axi4-lite slave: one write and one read at a time
  // ---------------------------------------------------------------
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic awready_reg;
  logic wready_reg;

  // an item moves at the edge where valid and ready are both high
  wire aw_take = AWVALID_IN & awready_reg;
  wire w_take = WVALID_IN & wready_reg;
  wire wr_go = aw_got_reg & w_got_reg & ~bvalid_reg;
  wire wr_stat = wr_go & (awaddr_reg == PLS_STATUS_OFFS) & wstrb_reg[0];
  wire wr_mask = wr_go & (awaddr_reg == PLS_MASK_OFFS) & wstrb_reg[0];
  wire wr_ctrl = wr_go & (awaddr_reg == PLS_CTRL_OFFS) & wstrb_reg[0];
  wire wr_hit = (awaddr_reg == PLS_STATUS_OFFS) |
                (awaddr_reg == PLS_MASK_OFFS) |
                (awaddr_reg == PLS_CTRL_OFFS) |
                (awaddr_reg == PLS_STATE_OFFS);
  // read data stands one cycle after the address is taken
  wire ar_take = ARVALID_IN & arready_reg;

  // read mux, address decode by chain
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (ARADDR_IN == PLS_STATUS_OFFS) begin
      rd_mux = {27'h000_0000, stat_reg};
    end else if (ARADDR_IN == PLS_MASK_OFFS) begin
      rd_mux = {27'h000_0000, mask_reg};
    end else if (ARADDR_IN == PLS_CTRL_OFFS) begin
      rd_mux = {31'h0000_0000, run_reg};
    end else if (ARADDR_IN == PLS_STATE_OFFS) begin
      rd_mux = {24'h00_0000, drive_reg, latch_reg, fault, cnt_eight,
                1'b0, cnt_reg};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // write channel capture and response
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= PLS_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= AWADDR_IN;
      end
      if (w_take) begin
        w_got_reg <= 1'b1;
        wdata_reg <= WDATA_IN;
        wstrb_reg <= WSTRB_IN;
      end
      if (wr_go) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? PLS_RESP_OKAY : PLS_RESP_SLVERR;
      end else if (bvalid_reg & BREADY_IN) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= PLS_RESP_OKAY;
    end else begin
      arready_reg <= ~ar_take & ~rvalid_reg;
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_hit ? PLS_RESP_OKAY : PLS_RESP_SLVERR;
      end else if (rvalid_reg & RREADY_IN) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // control, mask and sticky status; set wins over clear
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      run_reg <= PLS_CTRL_RST[0];
      mask_reg <= PLS_MASK_RST;
      stat_reg <= 5'h00;
      irq_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        run_reg <= wdata_reg[0];
      end
      if (wr_mask) begin
        mask_reg <= wdata_reg[4:0];
      end
      stat_reg <= (stat_reg & ~(wr_stat ? wdata_reg[4:0] : 5'h00)) | ev;
      irq_reg <= irq_any;
    end
  end

  // ready high while the channel can take an item
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
    end else begin
      awready_reg <= ~aw_take & ~aw_got_reg & ~bvalid_reg;
      wready_reg <= ~w_take & ~w_got_reg & ~bvalid_reg;
    end
  end
  assign AWREADY_OUT = awready_reg;
  assign WREADY_OUT = wready_reg;
  assign BVALID_OUT = bvalid_reg;
  assign BRESP_OUT = bresp_reg;
  assign ARREADY_OUT = arready_reg;
  assign RVALID_OUT = rvalid_reg;
  assign RDATA_OUT = rdata_reg;
  assign RRESP_OUT = rresp_reg;
  assign IRQ_OUT = irq_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  // latch and drive
  set_dominant_a: assert property (
    trip_s & osc_s |=> latch_reg & !drive_reg)
    else $error("trip with pulse must leave latch set");
  pulse_low_a: assert property (
    osc_s |=> !drive_reg)
    else $error("drive high during oscillator pulse");
  pulse_start_a: assert property (
    osc_fall & !fault & !trip_s & !latch_reg |=> drive_reg)
    else $error("drive did not start after pulse fall");
  rise_on_fall_a: assert property (
    $rose(drive_reg) |-> $past(osc_fall))
    else $error("drive rose without a pulse fall");
  trip_hold_a: assert property (
    trip_s |=> latch_reg & !drive_reg)
    else $error("trip did not set latch and stop drive");
  latch_off_a: assert property (
    latch_reg |-> !drive_reg)
    else $error("drive high while latch set");
  inhibit_low_a: assert property (
    inhibit |=> !drive_reg)
    else $error("drive high after inhibit");
  lock_low_a: assert property (
    lock_s |=> !drive_reg)
    else $error("drive high under lockout");
  otemp_low_a: assert property (
    !otemp_ok_s |=> !drive_reg)
    else $error("drive high while hot");
  shdn_low_a: assert property (
    !shdn_ok_s |=> !drive_reg && cnt_reg == 3'h7)
    else $error("shutdown did not stop drive or hold seven");

  // restart counter
  cnt_step_a: assert property (
    !sue_fall && shdn_ok_s |=> cnt_reg == $past(cnt_reg))
    else $error("counter moved without start-up enable fall");
  cnt_eight_a: assert property (
    sue_fall && shdn_ok_s && cnt_reg == 3'h7 |=> cnt_reg == 3'h0)
    else $error("seven did not step to eight");
  gate_eight_a: assert property (
    !cnt_eight |=> !drive_reg)
    else $error("drive high away from count eight");

  // status and interrupt
  stat_set_a: assert property (
    |ev |=> (stat_reg & $past(ev)) == $past(ev))
    else $error("event lost against a status clear");
  irq_on_a: assert property (
    irq_any |=> IRQ_OUT)
    else $error("interrupt low with unmasked status");
  irq_off_a: assert property (
    !irq_any |=> !IRQ_OUT)
    else $error("interrupt high with no unmasked status");

  // bus channels
  bvalid_hold_a: assert property (
    BVALID_OUT && !BREADY_IN |=> BVALID_OUT)
    else $error("write response dropped before ready");
  rvalid_hold_a: assert property (
    RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
    else $error("read data dropped or changed before ready");
  awready_idle_a: assert property (
    AWREADY_OUT && !AWVALID_IN |=> AWREADY_OUT)
    else $error("write address ready fell while idle");
  wready_idle_a: assert property (
    WREADY_OUT && !WVALID_IN |=> WREADY_OUT)
    else $error("write data ready fell while idle");

  // main scenarios
  run_cv: cover property (drive_reg ##[1:50] !drive_reg);
  trip_cv: cover property (drive_reg ##1 trip_s);
  restart_cv: cover property (sue_fall && cnt_reg == 3'h7);
  shdn_cv: cover property (shdn_ok_s && !shdn_d_reg);
  irq_cv: cover property (irq_any ##1 IRQ_OUT);
endmodule

//--- rtl/pls_pkg.sv
// package of constants for the pulse latch, shutdown and restart block
//
// Operation
// - set wins over reset in latch
// - oscillator pulse resets latch, drive low
// - pulse falling edge starts conduction unless inhibited
// - comparator trip sets latch until next cycle
// - inhibit path forces drive low on faults
// - drive held low during supply lockout
// - overtemperature low forces drive low until recovery
// - supply fault runs eight-cycle restart count
// - shutdown low stops drive immediately
// - shutdown holds restart counter at seven
// - released counter steps seven to eight, enabling
// - counter steps only on start-up enable fall
// - release on rising supply waits one cycle
// - resume only with full discharge, under two cycles
// - resume on next or second falling slope
// - counter preset to seven at power-up
// - start-up enable fall clocks the counter
package pls_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] PLS_STATUS_OFFS = 8'h00;
  localparam logic [7:0] PLS_MASK_OFFS = 8'h04;
  localparam logic [7:0] PLS_CTRL_OFFS = 8'h08;
  localparam logic [7:0] PLS_STATE_OFFS = 8'h0C;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int PLS_EV_TRIP = 0;
  localparam int PLS_EV_OTEMP = 1;
  localparam int PLS_EV_SHDN = 2;
  localparam int PLS_EV_LOCK = 3;
  localparam int PLS_EV_RESTART = 4;
  localparam int PLS_EV_W = 5;
  localparam logic [4:0] PLS_MASK_RST = 5'h00;
  localparam logic [0:0] PLS_CTRL_RST = 1'h1;
  localparam logic [5:0] PLS_SYNC_RST = 6'h0C; // ok indicators idle high
  localparam logic [2:0] PLS_CNT_PRESET = 3'h7;
  localparam logic [2:0] PLS_CNT_RUN = 3'h0;
  localparam logic [1:0] PLS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PLS_RESP_SLVERR = 2'h2;
endpackage

//--- testbench/pls_gate_model.sv
// gate driver stand-in that follows the drive pin
`timescale 1ns/1ps
module pls_gate_model #(
  parameter int DLY = 2
) (
  input wire logic clk_in, // system clock
  input wire logic drive_in, // gate command from the block
  output logic gate_on_out // switch conducting
);
  logic [7:0] pipe_reg;
  // turn-on lags the command, turn-off follows it at once
  always_ff @(posedge clk_in) begin
    pipe_reg <= {pipe_reg[6:0], drive_in};
  end
  assign gate_on_out = drive_in & pipe_reg[DLY-1];
endmodule

//--- testbench/pls_core_tb.sv
// self-checking bench for the pulse latch and restart block
`timescale 1ns/1ps
module pls_core_tb;
  import pls_pkg::*;
  logic clk = 0, rst_n = 0;
  logic osc = 0, trip = 0, ot_ok = 1, sd_ok = 1, lock = 0, su = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rd, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, drive, irq, gate;
  logic [1:0] bresp, rresp, rr, br;
  int err_total = 0, checks = 0, cyc = 0;
  // ---------------------------------------------------------------
  // clock, device and far side
  // ---------------------------------------------------------------
  always #12.5 clk = ~clk;
  pls_core u_dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .OSC_PULSE_IN(osc),
    .TRIP_IN(trip), .OTEMP_OK_IN(ot_ok), .SHDN_OK_IN(sd_ok),
    .LOCK_IN(lock), .STARTUP_EN_IN(su), .AWADDR_IN(awaddr),
    .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata),
    .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready),
    .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
    .RREADY_IN(rready), .DRIVE_OUT(drive), .IRQ_OUT(irq));
  pls_gate_model #(.DLY(2)) u_gate (.clk_in(clk), .drive_in(drive),
    .gate_on_out(gate));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // both channels offered together, each dropped when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    br = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axi_read(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // oscillator pulse, drive checked while it is high
  task automatic pulse();
    osc <= 1'b1;
    wt(6);
    chk_bit("drive_in_pulse", 1'b0, drive);
    osc <= 1'b0;
    wt(6);
  endtask
  task automatic su_fall();
    su <= 1'b1;
    wt(4);
    su <= 1'b0;
    wt(6);
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    wt(6);
    rst_n <= 1'b1;
    wt(2);
    axi_read(PLS_STATE_OFFS);
    chk_reg("state_rst", 32'h0000_0007, rd & 32'h0000_0097);
    axi_read(PLS_MASK_OFFS);
    chk_reg("mask_rst", 32'h0000_0000, rd);
    axi_read(PLS_CTRL_OFFS);
    chk_reg("ctrl_rst", 32'h0000_0001, rd);
    axi_read(8'h10);
    chk_reg("bad_data", 32'h0000_0000, rd);
    chk_reg("bad_resp", 32'h0000_0002, {30'h0, rr});
    axi_write(8'h10, 32'h0000_0001);
    chk_reg("bad_wresp", 32'h0000_0002, {30'h0, br});
    pulse();
    chk_bit("drive_cnt7", 1'b0, drive);
    su_fall();
    axi_read(PLS_STATE_OFFS);
    chk_reg("cnt_eight", 32'h0000_0010, rd & 32'h0000_0017);
    pulse();
    chk_bit("drive_on", 1'b1, drive);
    chk_bit("gate_on", 1'b1, gate);
    // trip ends conduction until the next cycle
    trip <= 1'b1;
    wt(3);
    trip <= 1'b0;
    wt(5);
    chk_bit("drive_trip", 1'b0, drive);
    chk_bit("irq_masked", 1'b0, irq);
    wt(10);
    chk_bit("drive_held", 1'b0, drive);
    // set and reset together
    trip <= 1'b1;
    pulse();
    chk_bit("drive_set_dom", 1'b0, drive);
    trip <= 1'b0;
    pulse();
    chk_bit("drive_back", 1'b1, drive);
    // pending trip event raises the line once unmasked
    axi_write(PLS_MASK_OFFS, 32'h0000_0001);
    chk_reg("mask_wresp", 32'h0000_0000, {30'h0, br});
    wt(4);
    chk_bit("irq_on", 1'b1, irq);
    axi_write(PLS_STATUS_OFFS, 32'h0000_001F);
    wt(4);
    chk_bit("irq_clr", 1'b0, irq);
    // restart count: pulses between falls must not step it
    su_fall();
    pulse();
    chk_bit("drive_cnt1", 1'b0, drive);
    repeat (7) su_fall();
    axi_read(PLS_STATE_OFFS);
    chk_reg("cnt_wrap", 32'h0000_0010, rd & 32'h0000_0017);
    pulse();
    chk_bit("drive_restart", 1'b1, drive);
    // supply lockout and overtemperature inhibit
    lock <= 1'b1;
    wt(6);
    chk_bit("drive_lock", 1'b0, drive);
    pulse();
    chk_bit("drive_lock_p", 1'b0, drive);
    lock <= 1'b0;
    pulse();
    ot_ok <= 1'b0;
    wt(6);
    chk_bit("drive_hot", 1'b0, drive);
    pulse();
    chk_bit("drive_hot_p", 1'b0, drive);
    ot_ok <= 1'b1;
    pulse();
    chk_bit("drive_cool", 1'b1, drive);
    // shutdown, counter held at seven, release on rising supply
    sd_ok <= 1'b0;
    wt(6);
    chk_bit("drive_shdn", 1'b0, drive);
    su_fall();
    axi_read(PLS_STATE_OFFS);
    chk_reg("cnt_held", 32'h0000_0007, rd & 32'h0000_0017);
    su <= 1'b1;
    wt(4);
    sd_ok <= 1'b1;
    wt(6);
    pulse();
    chk_bit("drive_wait", 1'b0, drive);
    su <= 1'b0;
    wt(6);
    axi_read(PLS_STATE_OFFS);
    chk_reg("cnt_resume", 32'h0000_0010, rd & 32'h0000_0017);
    pulse();
    chk_bit("drive_resume", 1'b1, drive);
    // run bit cleared stops the drive, set again resumes it
    axi_write(PLS_CTRL_OFFS, 32'h0000_0000);
    chk_reg("ctrl_wresp", 32'h0000_0000, {30'h0, br});
    wt(4);
    chk_bit("drive_stop", 1'b0, drive);
    axi_write(PLS_CTRL_OFFS, 32'h0000_0001);
    pulse();
    chk_bit("drive_run", 1'b1, drive);
    summarize();
  end
endmodule
